//--- common/afd_pkg.sv
package afd_pkg;
   localparam int unsigned AFD_WIDTH      = 8;
   localparam int unsigned AFD_RF_DEPTH   = 8;
   localparam int unsigned AFD_RF_AW      = 3;
   // Register map, word index times four
   localparam logic [3:0] AFD_OFF_SELECT  = 4'h0;
   localparam logic [3:0] AFD_OFF_DIN     = 4'h4;
   localparam logic [3:0] AFD_OFF_STATUS  = 4'h8;
   localparam logic [3:0] AFD_OFF_WR      = 4'hc;
   // Select word layout: op[3:0], dest[5:4], src[9:7], carry[10], pc_override[11], go[12]
   localparam int unsigned AFD_SEL_OP_LSB = 0;
   localparam int unsigned AFD_SEL_D_LSB  = 4;
   localparam int unsigned AFD_SEL_S_LSB  = 7;
   localparam int unsigned AFD_SEL_CIN    = 10;
   localparam int unsigned AFD_SEL_PCO    = 11;
   localparam int unsigned AFD_SEL_GO     = 12;
   localparam logic [1:0] AFD_D_RF_TO_RF  = 2'h0;
   localparam logic [1:0] AFD_D_RF_TO_WR  = 2'h1;
   localparam logic [1:0] AFD_D_RF_MIXED  = 2'h2;
   localparam logic [1:0] AFD_D_NON_RF    = 2'h3;
   localparam logic [2:0] AFD_RF_PC_IDX   = 3'h7;
   localparam logic [3:0] AFD_OP_CLEAR    = 4'h0;
   localparam logic [3:0] AFD_OP_BMINUSA  = 4'h1;
   localparam logic [3:0] AFD_OP_AMINUSB  = 4'h2;
   localparam logic [3:0] AFD_OP_APLUSB   = 4'h3;
   localparam logic [3:0] AFD_OP_BINC     = 4'h4;
   localparam logic [3:0] AFD_OP_BCPL     = 4'h5;
   localparam logic [3:0] AFD_OP_AINC     = 4'h6;
   localparam logic [3:0] AFD_OP_ACPL     = 4'h7;
   typedef enum logic [1:0] {AFD_A_DIP, AFD_A_RF} afd_asel_t;
   typedef enum logic [1:0] {AFD_B_DIP, AFD_B_WR, AFD_B_XWR} afd_bsel_t;
   typedef enum logic [2:0] {AFD_DST_DOP, AFD_DST_RF, AFD_DST_WR, AFD_DST_XWR} afd_dst_t;
   typedef enum logic [1:0] {AFD_ALU_FULL, AFD_ALU_LIMITED} afd_mode_t;
endpackage : afd_pkg

//--- common/afd_ctl_if.sv
`timescale 1ns/10ps
interface afd_ctl_if
   import afd_pkg::*;
   #(parameter int unsigned WIDTH = AFD_WIDTH);
   logic [3:0]       op;
   logic             carry_in;
   logic [WIDTH-1:0] a;
   logic [WIDTH-1:0] b;
   logic [WIDTH-1:0] f;
   afd_asel_t        asel;
   afd_bsel_t        bsel;
   afd_dst_t         dst;
   logic             xwr_addr;
   logic             valid;
   modport dec (output asel, output bsel, output dst, output xwr_addr, output valid, input op);
   modport top (input asel, input bsel, input dst, input xwr_addr, input valid, output op,
                output carry_in, output a, output b, input f);
   modport alu (input op, input carry_in, input a, input b, output f);
endinterface : afd_ctl_if

//--- hdl/afd_alu.sv
`timescale 1ns/10ps
module afd_alu
   import afd_pkg::*;
   (
   afd_ctl_if.alu c
   );
   localparam int unsigned W = $bits(c.a);
   wire logic [W-1:0] ones   = {W{1'b1}};
   wire logic [W-1:0] cin_w  = {{(W-1){1'b0}}, c.carry_in};
   wire logic [W-1:0] nota   = ~c.a;
   wire logic [W-1:0] notb   = ~c.b;
   logic      [W-1:0] f_comb;
   always_comb begin
      case (c.op)
         AFD_OP_CLEAR:   f_comb = c.carry_in ? '0 : ones;               // see [RULE9]
         AFD_OP_BMINUSA: f_comb = c.b + nota + cin_w;                   // see [RULE6]
         AFD_OP_AMINUSB: f_comb = c.a + notb + cin_w;                   // see [RULE5]
         AFD_OP_APLUSB:  f_comb = c.a + c.b + cin_w;                    // see [RULE7]
         AFD_OP_BINC:    f_comb = c.b + cin_w;                          // see [RULE8]
         AFD_OP_BCPL:    f_comb = notb + cin_w;                         // see [RULE8]
         AFD_OP_AINC:    f_comb = c.a + cin_w;                          // see [RULE8]
         AFD_OP_ACPL:    f_comb = nota + cin_w;                         // see [RULE8]
         4'h8:           f_comb = c.carry_in ? c.a : (c.a & notb);      // see [RULE2]
         4'h9:           f_comb = c.carry_in ? c.a : (c.a ^ c.b);
         4'ha:           f_comb = c.carry_in ? nota : ~(c.a ^ c.b);
         4'hb:           f_comb = c.carry_in ? nota : (nota & c.b);
         4'hc:           f_comb = c.carry_in ? c.b : (c.a & c.b);
         4'hd:           f_comb = c.a | c.b;
         4'he:           f_comb = c.carry_in ? nota : (nota | c.b);
         default:        f_comb = c.carry_in ? c.a : (c.a | c.b);
      endcase
   end
   assign c.f = f_comb;
endmodule : afd_alu

//--- hdl/afd_decode.sv
`timescale 1ns/10ps
module afd_decode
   import afd_pkg::*;
   (
   input  wire logic [1:0] dest,
   input  wire logic [2:0] src,
   afd_ctl_if.dec          c
   );
   // Operand and destination choice by destination code, and by source code for non-register-file operations
   always_comb begin
      c.asel     = AFD_A_RF;
      c.bsel     = AFD_B_WR;
      c.dst      = AFD_DST_RF;
      c.xwr_addr = 1'b0;
      c.valid    = 1'b1;
      case (dest)
         AFD_D_RF_TO_RF: begin
            c.dst = AFD_DST_RF;                                          // see [RULE15]
         end
         AFD_D_RF_TO_WR: begin
            c.dst = AFD_DST_WR;
            c.xwr_addr = 1'b1;                                          // see [RULE14]
         end
         AFD_D_RF_MIXED: begin
            c.dst = AFD_DST_DOP;
         end
         AFD_D_NON_RF: begin
            c.asel = AFD_A_DIP;                                         // see [RULE16]
            case (src)
               3'h0: begin
                  c.dst = AFD_DST_DOP;
                  c.xwr_addr = 1'b1;
               end
               3'h1: begin
                  c.dst = AFD_DST_WR;                                   // see [RULE10]
                  c.xwr_addr = 1'b1;
               end
               3'h3: begin
                  c.bsel = AFD_B_XWR;
                  c.dst  = AFD_DST_WR;
               end
               3'h4: c.dst = AFD_DST_XWR;
               3'h6: begin
                  c.bsel = AFD_B_XWR;
                  c.dst  = AFD_DST_XWR;
               end
               3'h7: begin
                  c.bsel = AFD_B_XWR;
                  c.dst  = AFD_DST_DOP;
               end
               default: begin
                  c.dst   = AFD_DST_DOP;                                // see [RULE12]
                  c.valid = 1'b0;
               end
            endcase
         end
         default: c.valid = 1'b0;
      endcase
   end
endmodule : afd_decode

//--- hdl/afd_top.sv
`timescale 1ns/10ps
// Summary of operation
// [RULE1] 4-bit function field picks one of 16 ALU functions, both carry levels.
// [RULE2] Eight arithmetic and eight Boolean functions apply to any operation.
// [RULE3] A from data input or register file; B from data input, WR or extended WR; the code never selects data input for B.
// [RULE4] Result goes to exactly one destination selected by destination/source fields; the code also loads data out on every operation.
// [RULE5] Code LLHL gives A minus B, minus one more when carry low.
// [RULE6] Code LLLH gives B minus A, minus one more when carry low.
// [RULE7] Addition gives A plus B, plus one when carry high.
// [RULE8] Copy, increment, one's and two's complement transfers by carry level.
// [RULE9] Code zero clears with carry high, presets with carry low.
// [RULE10] Destination HH, source LLH combines data input and working register.
// [RULE11] Controller supplies carry into least significant slice as function needs.
// [RULE12] Source field selects register location or extends the function field.
// [RULE13] Extended non-register operations limited to add, subtract or bypass; the code allows all 16 functions there.
// [RULE14] Marked operations put extended WR on address out; override selects PC.
// [RULE15] Destinations LL, LH, HL index register locations 0-7, 7 is PC.
// [RULE16] Destination HH neither reads nor writes the register file.
// [RULE17] Registers load on clock edge; data out shows result.
module afd_top
   import afd_pkg::*;
   #(
   parameter int unsigned WIDTH = AFD_WIDTH
   )
   (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [3:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   output logic      [WIDTH-1:0]  data_out_port,
   output logic      [WIDTH-1:0]  address_out_port
   );
   afd_ctl_if #(.WIDTH(WIDTH)) ctl ();

   logic [WIDTH-1:0] reg_file_reg [AFD_RF_DEPTH];
   logic [WIDTH-1:0] working_reg;
   logic [WIDTH-1:0] extended_working_reg;
   logic [12:0]      select_reg;
   logic [WIDTH-1:0] data_in_port_reg;
   logic             ack_reg;
   logic             illegal_reg;

   wire logic [3:0]       function_select_field = select_reg[AFD_SEL_OP_LSB +: 4];
   wire logic [1:0]       dest_field            = select_reg[AFD_SEL_D_LSB +: 2];
   wire logic [2:0]       src_field             = select_reg[AFD_SEL_S_LSB +: 3];
   wire logic             alu_carry_in          = select_reg[AFD_SEL_CIN];   // see [RULE11]
   wire logic             program_counter_override = select_reg[AFD_SEL_PCO];
   wire logic             go                    = select_reg[AFD_SEL_GO];

   afd_decode u_dec (
      .dest (dest_field),
      .src  (src_field),
      .c    (ctl)
   );

   afd_alu u_alu (
      .c (ctl)
   );

   // Operand routing
   wire logic [WIDTH-1:0] rf_word = reg_file_reg[src_field];              // see [RULE15]
   assign ctl.op       = function_select_field;                           // see [RULE1]
   assign ctl.carry_in = alu_carry_in;
   assign ctl.a = (ctl.asel == AFD_A_RF) ? rf_word : data_in_port_reg;   // see [RULE3]
   assign ctl.b = (ctl.bsel == AFD_B_XWR) ? extended_working_reg :
                  (ctl.bsel == AFD_B_DIP) ? data_in_port_reg : working_reg;

   // Single destination enables
   wire logic do_op   = go && ctl.valid;
   wire logic rf_we   = do_op && (ctl.dst == AFD_DST_RF);                 // see [RULE4]
   wire logic wr_we   = do_op && (ctl.dst == AFD_DST_WR);
   wire logic xwr_we  = do_op && (ctl.dst == AFD_DST_XWR);

   // Address out source: the override wins, then the operation's mark
   wire logic [WIDTH-1:0] pc_word = reg_file_reg[AFD_RF_PC_IDX];
   logic      [WIDTH-1:0] addr_next;
   always_comb begin
      addr_next = working_reg;
      if (program_counter_override) begin
         addr_next = pc_word;                                             // see [RULE14]
      end else if (ctl.xwr_addr) begin
         addr_next = extended_working_reg;
      end
   end

   // Bus decode
   function automatic logic hit_offset(input logic [3:0] adr, input logic [3:0] off);
      return adr == off;
   endfunction : hit_offset

   // One answer cycle per request; writes land only while waitrequest is low
   wire logic bus_req     = avs_read || avs_write;
   wire logic take_req    = bus_req && !ack_reg;
   wire logic wr_accept   = avs_write && !avs_waitrequest;
   wire logic rd_take     = avs_read && !ack_reg;
   wire logic select_we   = wr_accept && hit_offset(avs_address, AFD_OFF_SELECT);
   wire logic din_we      = wr_accept && hit_offset(avs_address, AFD_OFF_DIN);
   wire logic status_clr  = wr_accept && hit_offset(avs_address, AFD_OFF_STATUS) && avs_writedata[0];
   wire logic illegal_set = go && !ctl.valid;
   wire logic [31:0] rd_mux =
      hit_offset(avs_address, AFD_OFF_SELECT) ? {19'h0, select_reg} :
      hit_offset(avs_address, AFD_OFF_DIN)    ? 32'(data_in_port_reg) :
      hit_offset(avs_address, AFD_OFF_STATUS) ? {31'h0, illegal_reg} :
      hit_offset(avs_address, AFD_OFF_WR)     ? 32'({extended_working_reg, working_reg}) : 32'h0;

   // Next values
   logic [12:0] select_next;
   always_comb begin
      select_next = select_reg;
      select_next[AFD_SEL_GO] = 1'b0;
      if (select_we) begin
         select_next = avs_writedata[12:0];
      end
   end

   // A new illegal code wins over a clear in the same cycle
   logic illegal_next;
   always_comb begin
      illegal_next = illegal_reg;
      if (illegal_set) begin
         illegal_next = 1'b1;                                              // see [RULE12]
      end else if (status_clr) begin
         illegal_next = 1'b0;
      end
   end

   wire logic [WIDTH-1:0] data_in_port_next     = din_we ? avs_writedata[WIDTH-1:0] : data_in_port_reg;
   wire logic [WIDTH-1:0] working_next          = wr_we ? ctl.f : working_reg;
   wire logic [WIDTH-1:0] extended_working_next = xwr_we ? ctl.f : extended_working_reg;
   wire logic [WIDTH-1:0] data_out_next         = do_op ? ctl.f : data_out_port;
   wire logic [31:0]      readdata_next         = rd_take ? rd_mux : avs_readdata;
   wire logic             ack_next              = take_req;
   wire logic             waitrequest_next      = !take_req;

   generate
      for (genvar i = 0; i < AFD_RF_DEPTH; i++) begin : g_rf
         wire logic rf_hit = rf_we && (src_field == 3'(i));
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               reg_file_reg[i] <= '0;
            end else if (rf_hit) begin
               reg_file_reg[i] <= ctl.f;                                  // see [RULE17]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         working_reg <= '0;
      end else begin
         working_reg <= working_next;                                     // see [RULE17]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         extended_working_reg <= '0;
      end else begin
         extended_working_reg <= extended_working_next;                   // see [RULE13]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         select_reg <= '0;
      end else begin
         select_reg <= select_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_in_port_reg <= '0;
      end else begin
         data_in_port_reg <= data_in_port_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         illegal_reg <= 1'b0;
      end else begin
         illegal_reg <= illegal_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= '0;
      end else begin
         avs_readdata <= readdata_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_out_port <= '0;
      end else begin
         data_out_port <= data_out_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         address_out_port <= '0;
      end else begin
         address_out_port <= addr_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= waitrequest_next;
      end
   end
endmodule : afd_top

//--- test/afd_top_chk.sv
`timescale 1ns/10ps
module afd_top_chk
   import afd_pkg::*;
   #(
   parameter int unsigned WIDTH = AFD_WIDTH
   )
   (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [3:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [31:0]      avs_readdata,
   input  wire logic             avs_waitrequest,
   input  wire logic [WIDTH-1:0] data_out_port,
   input  wire logic [WIDTH-1:0] address_out_port
   );
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire       sel_hit = avs_write && !avs_waitrequest && avs_address == AFD_OFF_SELECT;
   wire       go      = sel_hit && avs_writedata[AFD_SEL_GO];
   wire [1:0] w_d     = avs_writedata[AFD_SEL_D_LSB +: 2];
   wire [2:0] w_s     = avs_writedata[AFD_SEL_S_LSB +: 3];
   wire       zero_op = go && w_d == AFD_D_NON_RF && w_s == 3'h0 && avs_writedata[3:0] == AFD_OP_CLEAR;
   wire       bad_src = w_d == AFD_D_NON_RF && (w_s == 3'h2 || w_s == 3'h5);
   logic [3:0] hist_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) hist_reg <= 4'h0;
      else hist_reg <= {hist_reg[2:0], sel_hit};
   end
   property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   property p_answer; (avs_read || avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
   property p_unmapped; avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_dop_cause; hist_reg == 4'h0 && !sel_hit |=> $stable(data_out_port); endproperty
   a_dop_cause: assert property (p_dop_cause) else $error("dop moved unprompted");
   property p_aop_cause; hist_reg == 4'h0 && !sel_hit |=> $stable(address_out_port); endproperty
   a_aop_cause: assert property (p_aop_cause) else $error("aop moved unprompted");
   property p_illegal; go && bad_src && hist_reg == 4'h0 |=> $stable(data_out_port)[*5]; endproperty
   a_illegal: assert property (p_illegal) else $error("illegal op executed");
   property p_clear; zero_op && avs_writedata[AFD_SEL_CIN] |-> ##[1:5] data_out_port == '0; endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
   property p_preset; zero_op && !avs_writedata[AFD_SEL_CIN] |-> ##[1:5] data_out_port == '1; endproperty
   a_preset: assert property (p_preset) else $error("preset failed");
endmodule : afd_top_chk
bind afd_top afd_top_chk #(.WIDTH(WIDTH)) u_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .data_out_port(data_out_port), .address_out_port(address_out_port));

//--- test/afd_ctl_model.sv
`timescale 1ns/10ps
module afd_ctl_model
   import afd_pkg::*;
   (
   input  wire logic        clk,
   output logic [3:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
   );
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   // Request held until waitrequest is seen low at an edge
   task automatic xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      logic done;
      done = 1'b0;
      rd = 32'h0;
      @(posedge clk);
      avs_address <= adr;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      while (!done) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) begin
            done = 1'b1;
            rd = avs_readdata;
         end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~adr;
      avs_writedata <= ~wd;
   endtask : xfer
endmodule : afd_ctl_model

//--- test/test_alu_function_operation_decode.sv
`timescale 1ns/10ps
module test_alu_function_operation_decode
   import afd_pkg::*;
   ;
   logic                 clk;
   logic                 rst_b;
   logic [3:0]           avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [31:0]          avs_writedata;
   logic [31:0]          avs_readdata;
   logic                 avs_waitrequest;
   logic [AFD_WIDTH-1:0] data_out_port;
   logic [AFD_WIDTH-1:0] address_out_port;
   logic [31:0]          rd;
   int                   fails;
   int                   tests_run;
   int                   cyc;
   afd_top #(.WIDTH(AFD_WIDTH)) u_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .data_out_port(data_out_port), .address_out_port(address_out_port));
   afd_ctl_model u_ctl (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         $display("[ERR] cycles expected below %0d seen %0d", 5000, cyc);
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic bw(input logic [3:0] a, input logic [31:0] d);
      u_ctl.xfer(1'b1, a, d, rd);
   endtask : bw
   task automatic br(input logic [3:0] a);
      u_ctl.xfer(1'b0, a, 32'h0, rd);
   endtask : br
   function automatic logic [7:0] ref_alu(input logic [3:0] op, input logic c, input logic [7:0] a, input logic [7:0] b);
      case (op)
         4'h0: return c ? 8'h00 : 8'hff;
         4'h1: return b - a - {7'h0, !c};
         4'h2: return a - b - {7'h0, !c};
         4'h3: return a + b + {7'h0, c};
         4'h4: return b + {7'h0, c};
         4'h5: return ~b + {7'h0, c};
         4'h6: return a + {7'h0, c};
         default: return ~a + {7'h0, c};
      endcase
   endfunction : ref_alu
   task automatic run(input logic [3:0] op, input logic [1:0] d, input logic [2:0] s, input logic c, input logic p);
      logic [31:0] w;
      w = 32'h0;
      w[3:0] = op;
      w[AFD_SEL_D_LSB +: 2] = d;
      w[AFD_SEL_S_LSB +: 3] = s;
      w[AFD_SEL_CIN] = c;
      w[AFD_SEL_PCO] = p;
      w[AFD_SEL_GO] = 1'b1;
      bw(AFD_OFF_SELECT, w);
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : run
   task automatic t_ops();
      bw(AFD_OFF_DIN, 32'h5a);
      run(AFD_OP_AINC, AFD_D_NON_RF, 3'h1, 1'b0, 1'b0);
      br(AFD_OFF_WR);
      chk("wr", 32'h5a, rd);
      bw(AFD_OFF_DIN, 32'h3c);
      for (int i = 0; i < 16; i++) begin
         run({1'b0, i[3:1]}, AFD_D_NON_RF, 3'h0, i[0], 1'b0);
         chk("dop", 32'(ref_alu({1'b0, i[3:1]}, i[0], 8'h3c, 8'h5a)), 32'(data_out_port));
         chk("aop", 32'h0, 32'(address_out_port));
      end
      run(4'hd, AFD_D_NON_RF, 3'h0, 1'b1, 1'b0);
      chk("dop_or", 32'h7e, 32'(data_out_port));
      $display("t_ops done");
   endtask : t_ops
   task automatic t_dest();
      run(AFD_OP_APLUSB, AFD_D_NON_RF, 3'h4, 1'b0, 1'b0);
      br(AFD_OFF_WR);
      chk("xwr_wr", 32'h965a, rd);
      chk("aop", 32'h5a, 32'(address_out_port));
      run(AFD_OP_BINC, AFD_D_RF_TO_RF, 3'h3, 1'b1, 1'b0);
      run(AFD_OP_AINC, AFD_D_RF_MIXED, 3'h3, 1'b0, 1'b0);
      chk("rf3", 32'h5b, 32'(data_out_port));
      run(AFD_OP_BINC, AFD_D_RF_TO_RF, 3'h7, 1'b1, 1'b0);
      run(AFD_OP_AINC, AFD_D_RF_MIXED, 3'h7, 1'b0, 1'b1);
      chk("pc", 32'h5b, 32'(address_out_port));
      run(AFD_OP_APLUSB, AFD_D_RF_TO_WR, 3'h3, 1'b0, 1'b0);
      br(AFD_OFF_WR);
      chk("wr", 32'h96b5, rd);
      $display("t_dest done");
   endtask : t_dest
   task automatic t_illegal();
      run(AFD_OP_CLEAR, AFD_D_NON_RF, 3'h2, 1'b1, 1'b0);
      chk("dop", 32'hb5, 32'(data_out_port));
      br(AFD_OFF_STATUS);
      chk("status", 32'h1, rd);
      bw(AFD_OFF_STATUS, 32'h1);
      br(AFD_OFF_STATUS);
      chk("status", 32'h0, rd);
      br(4'h2);
      chk("unmapped", 32'h0, rd);
      $display("t_illegal done");
   endtask : t_illegal
   initial begin
      fails = 0;
      tests_run = 0;
      rst_b = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("dop", 32'h0, 32'(data_out_port));
      t_ops();
      t_dest();
      t_illegal();
      summarize();
   end
endmodule : test_alu_function_operation_decode
